/* File: inc/iepr_pkg.sv */
// package of the interrupt enable and priority register block:
// register addresses, reset values, bit positions and carrier types.
// assumes a single system clock shared by core, peripherals and block.
package iepr_pkg;

   localparam logic [7:0] BASE_PRIO_ADDR = 8'hB8;
   localparam logic [7:0] EXT_EN_ADDR    = 8'hE6;
   localparam logic [7:0] EXT_PRIO_ADDR  = 8'hF6;

   localparam logic [7:0] BASE_PRIO_RESET = 8'h80;
   localparam logic [7:0] EXT_EN_RESET    = 8'h00;
   localparam logic [7:0] EXT_PRIO_RESET  = 8'h00;

   // top bit of the base priority register is fixed
   localparam int         BASE_FIXED_BIT = 7;
   localparam logic [7:0] BASE_FIXED_MASK = 8'h80;

   // base priority bits, also the source slot numbers 0..6
   localparam int EXT_IRQ0_PRIORITY_BIT = 0;
   localparam int TIMER0_PRIORITY_BIT   = 1;
   localparam int EXT_IRQ1_PRIORITY_BIT = 2;
   localparam int TIMER1_PRIORITY_BIT   = 3;
   localparam int UART_PRIORITY_BIT     = 4;
   localparam int TIMER2_PRIORITY_BIT   = 5;
   localparam int SPI_PRIORITY_BIT      = 6;

   // extended enable and priority bits share positions
   localparam int SMBUS_BIT         = 0;
   localparam int PORT_MATCH_BIT    = 1;
   localparam int CONV_WINDOW_BIT   = 2;
   localparam int CONV_DONE_BIT     = 3;
   localparam int COUNTER_ARRAY_BIT = 4;
   localparam int COMPARATOR_BIT    = 5;
   localparam int EXT_RESERVED_BIT  = 6;
   localparam int TIMER3_BIT        = 7;

   // extended source slot = bit + this offset; slot 13 is unused
   localparam int EXT_SLOT_BASE = 7;
   localparam int NUM_SLOTS     = 15;

   // pending flags of the peripherals
   typedef struct packed {
      logic       timer3_high_overflow_flag;
      logic       timer3_low_overflow_flag;
      logic       comparator_rise_flag;
      logic       comparator_fall_flag;
      logic [4:0] counter_array;
      logic       conv_done_flag;
      logic       conv_window_flag;
      logic       port_match;
      logic       smbus;
      logic [3:0] spi;
      logic       timer2_high;
      logic       timer2_low;
      logic       uart_tx;
      logic       uart_rx;
      logic       timer1;
      logic       ext_irq1;
      logic       timer0;
      logic       ext_irq0;
   } iepr_pending_t;

   // request presented to the core
   typedef struct packed {
      logic       valid;
      logic       high;
      logic [3:0] slot;
   } iepr_request_t;

endpackage : iepr_pkg

/* File: verilog/iepr_ctrl.sv */
// interrupt enable and priority registers with source arbitration.
// assumes: register port driven by the core on clock_in; pending flags,
// global enable and base enables come from logic on the same clock.
`timescale 1ns/1ps

module iepr_ctrl (
   input  wire logic                   clock_in,
   input  wire logic                   sys_rst_in,
   input  wire logic [7:0]             sfr_addr_in,
   input  wire logic                   sfr_wr_in,
   input  wire logic [7:0]             sfr_wdata_in,
   input  wire logic                   sfr_rd_in,
   input  wire logic                   global_irq_enable_in,
   input  wire logic [6:0]             base_enable_in,
   input  wire iepr_pkg::iepr_pending_t pending_in,
   input  wire logic                   irq_ack_in,
   input  wire logic                   irq_return_in,
   output logic [7:0]                  sfr_rdata_out,
   output logic                        sfr_hit_out,
   output iepr_pkg::iepr_request_t     irq_out,
   output logic [1:0]                  in_service_out
);

   logic [6:0]  base_source_priority;
   logic [7:0]  extended_source_enable;
   logic [7:0]  extended_source_priority;
   logic [14:0] raw_req;
   logic [14:0] enabled_req;
   logic [14:0] prio_vec;
   logic [14:0] high_req;
   logic [14:0] low_req;
   logic        low_active;
   logic        high_active;
   iepr_pkg::iepr_request_t next_irq;
   logic [14:0] slot_enable;

   // field views; each bit named for the source it controls
   logic        ext_irq0_priority_bit;
   logic        timer0_priority_bit;
   logic        ext_irq1_priority_bit;
   logic        timer1_priority_bit;
   logic        uart_priority_bit;
   logic        timer2_priority_bit;
   logic        spi_priority_bit;
   logic        smbus_enable_bit;
   logic        port_match_enable_bit;
   logic        conv_window_enable_bit;
   logic        conv_done_enable_bit;
   logic        counter_array_enable_bit;
   logic        comparator_enable_bit;
   logic        timer3_enable_bit;
   logic        smbus_priority_bit;
   logic        port_match_priority_bit;
   logic        conv_window_priority_bit;
   logic        conv_done_priority_bit;
   logic        counter_array_priority_bit;
   logic        comparator_priority_bit;
   logic        timer3_priority_bit;

   // index of the lowest set bit; lower slot wins within a level
   function automatic logic [3:0] first_slot(input logic [14:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = iepr_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : first_slot

   function automatic logic [7:0] read_value(input logic [7:0] addr,
                                             input logic [6:0] bp,
                                             input logic [7:0] ee,
                                             input logic [7:0] ep);
      logic [7:0] v;
      v = 8'h00;
      case (addr)
         iepr_pkg::BASE_PRIO_ADDR: v = iepr_pkg::BASE_FIXED_MASK
                                       | {1'b0, bp};
         iepr_pkg::EXT_EN_ADDR:    v = ee;
         iepr_pkg::EXT_PRIO_ADDR:  v = ep;
         default:                  v = 8'h00;
      endcase
      return v;
   endfunction : read_value

   function automatic logic is_mapped(input logic [7:0] addr);
      return (addr == iepr_pkg::BASE_PRIO_ADDR)
          || (addr == iepr_pkg::EXT_EN_ADDR)
          || (addr == iepr_pkg::EXT_PRIO_ADDR);
   endfunction : is_mapped

   // base priority: top bit is not stored, so writes to it are lost
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         base_source_priority <= iepr_pkg::BASE_PRIO_RESET[6:0];
      end else if (sfr_wr_in && sfr_addr_in == iepr_pkg::BASE_PRIO_ADDR) begin
         base_source_priority <= sfr_wdata_in[6:0];
      end
   end

   // reserved bit 6 is stored as written; software keeps it zero
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         extended_source_enable <= iepr_pkg::EXT_EN_RESET;
      end else if (sfr_wr_in && sfr_addr_in == iepr_pkg::EXT_EN_ADDR) begin
         extended_source_enable <= sfr_wdata_in;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         extended_source_priority <= iepr_pkg::EXT_PRIO_RESET;
      end else if (sfr_wr_in && sfr_addr_in == iepr_pkg::EXT_PRIO_ADDR) begin
         extended_source_priority <= sfr_wdata_in;
      end
   end

   // read data is registered; answer one cycle after the read strobe
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sfr_rdata_out <= 8'h00;
         sfr_hit_out   <= 1'b0;
      end else if (sfr_rd_in) begin
         sfr_rdata_out <= read_value(sfr_addr_in, base_source_priority,
                                     extended_source_enable,
                                     extended_source_priority);
         sfr_hit_out   <= is_mapped(sfr_addr_in);
      end else begin
         sfr_rdata_out <= 8'h00;
         sfr_hit_out   <= 1'b0;
      end
   end

   // base priority bits
   assign ext_irq0_priority_bit =
      base_source_priority[iepr_pkg::EXT_IRQ0_PRIORITY_BIT];
   assign timer0_priority_bit =
      base_source_priority[iepr_pkg::TIMER0_PRIORITY_BIT];
   assign ext_irq1_priority_bit =
      base_source_priority[iepr_pkg::EXT_IRQ1_PRIORITY_BIT];
   assign timer1_priority_bit =
      base_source_priority[iepr_pkg::TIMER1_PRIORITY_BIT];
   assign uart_priority_bit =
      base_source_priority[iepr_pkg::UART_PRIORITY_BIT];
   assign timer2_priority_bit =
      base_source_priority[iepr_pkg::TIMER2_PRIORITY_BIT];
   assign spi_priority_bit =
      base_source_priority[iepr_pkg::SPI_PRIORITY_BIT];

   // extended enables; reserved bit 6 has no view and gates nothing
   assign smbus_enable_bit =
      extended_source_enable[iepr_pkg::SMBUS_BIT];
   assign port_match_enable_bit =
      extended_source_enable[iepr_pkg::PORT_MATCH_BIT];
   assign conv_window_enable_bit =
      extended_source_enable[iepr_pkg::CONV_WINDOW_BIT];
   assign conv_done_enable_bit =
      extended_source_enable[iepr_pkg::CONV_DONE_BIT];
   assign counter_array_enable_bit =
      extended_source_enable[iepr_pkg::COUNTER_ARRAY_BIT];
   assign comparator_enable_bit =
      extended_source_enable[iepr_pkg::COMPARATOR_BIT];
   assign timer3_enable_bit =
      extended_source_enable[iepr_pkg::TIMER3_BIT];

   // extended priorities
   assign smbus_priority_bit =
      extended_source_priority[iepr_pkg::SMBUS_BIT];
   assign port_match_priority_bit =
      extended_source_priority[iepr_pkg::PORT_MATCH_BIT];
   assign conv_window_priority_bit =
      extended_source_priority[iepr_pkg::CONV_WINDOW_BIT];
   assign conv_done_priority_bit =
      extended_source_priority[iepr_pkg::CONV_DONE_BIT];
   assign counter_array_priority_bit =
      extended_source_priority[iepr_pkg::COUNTER_ARRAY_BIT];
   assign comparator_priority_bit =
      extended_source_priority[iepr_pkg::COMPARATOR_BIT];
   assign timer3_priority_bit =
      extended_source_priority[iepr_pkg::TIMER3_BIT];

   // gather source requests into slots; several flags share a slot
   always_comb begin
      raw_req      = 15'h0000;
      raw_req[0]   = pending_in.ext_irq0;
      raw_req[1]   = pending_in.timer0;
      raw_req[2]   = pending_in.ext_irq1;
      raw_req[3]   = pending_in.timer1;
      raw_req[4]   = pending_in.uart_rx | pending_in.uart_tx;
      raw_req[5]   = pending_in.timer2_low | pending_in.timer2_high;
      raw_req[6]   = |pending_in.spi;
      raw_req[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::SMBUS_BIT] =
         pending_in.smbus;
      raw_req[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::PORT_MATCH_BIT] =
         pending_in.port_match;
      raw_req[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::CONV_WINDOW_BIT] =
         pending_in.conv_window_flag;
      raw_req[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::CONV_DONE_BIT] =
         pending_in.conv_done_flag;
      raw_req[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::COUNTER_ARRAY_BIT] =
         |pending_in.counter_array;
      raw_req[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::COMPARATOR_BIT] =
         pending_in.comparator_rise_flag | pending_in.comparator_fall_flag;
      raw_req[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::TIMER3_BIT] =
         pending_in.timer3_low_overflow_flag
         | pending_in.timer3_high_overflow_flag;
   end

   // masking: extended enables gate slots 7..14, slot 13 never passes
   always_comb begin
      slot_enable = {8'h00, base_enable_in};
      slot_enable[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::SMBUS_BIT] =
         smbus_enable_bit;
      slot_enable[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::PORT_MATCH_BIT] =
         port_match_enable_bit;
      slot_enable[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::CONV_WINDOW_BIT] =
         conv_window_enable_bit;
      slot_enable[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::CONV_DONE_BIT] =
         conv_done_enable_bit;
      slot_enable[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::COUNTER_ARRAY_BIT] =
         counter_array_enable_bit;
      slot_enable[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::COMPARATOR_BIT] =
         comparator_enable_bit;
      slot_enable[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::TIMER3_BIT] =
         timer3_enable_bit;
      enabled_req = raw_req & slot_enable;
      if (!global_irq_enable_in) begin
         enabled_req = 15'h0000;
      end
   end

   // priority level per slot, slot numbers follow the bit positions
   always_comb begin
      prio_vec    = 15'h0000;
      prio_vec[0] = ext_irq0_priority_bit;
      prio_vec[1] = timer0_priority_bit;
      prio_vec[2] = ext_irq1_priority_bit;
      prio_vec[3] = timer1_priority_bit;
      prio_vec[4] = uart_priority_bit;
      prio_vec[5] = timer2_priority_bit;
      prio_vec[6] = spi_priority_bit;
      prio_vec[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::SMBUS_BIT] =
         smbus_priority_bit;
      prio_vec[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::PORT_MATCH_BIT] =
         port_match_priority_bit;
      prio_vec[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::CONV_WINDOW_BIT] =
         conv_window_priority_bit;
      prio_vec[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::CONV_DONE_BIT] =
         conv_done_priority_bit;
      prio_vec[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::COUNTER_ARRAY_BIT] =
         counter_array_priority_bit;
      prio_vec[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::COMPARATOR_BIT] =
         comparator_priority_bit;
      prio_vec[iepr_pkg::EXT_SLOT_BASE + iepr_pkg::TIMER3_BIT] =
         timer3_priority_bit;
      high_req = enabled_req & prio_vec;
      low_req  = enabled_req & ~prio_vec;
   end

   // high may interrupt a low routine; nothing interrupts a high one
   always_comb begin
      next_irq = '0;
      if (!high_active && |high_req) begin
         next_irq.valid = 1'b1;
         next_irq.high  = 1'b1;
         next_irq.slot  = first_slot(high_req);
      end else if (!high_active && !low_active && |low_req) begin
         next_irq.valid = 1'b1;
         next_irq.high  = 1'b0;
         next_irq.slot  = first_slot(low_req);
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_out <= '0;
      end else if (irq_ack_in) begin
         // presented request is being taken; drop it until re-evaluated
         irq_out <= '0;
      end else begin
         irq_out <= next_irq;
      end
   end

   // in-service levels; return retires the highest active level first,
   // and an ack in the same cycle still records its new level
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         high_active <= 1'b0;
         low_active  <= 1'b0;
      end else begin
         if (irq_return_in) begin
            if (high_active) begin
               high_active <= 1'b0;
            end else begin
               low_active <= 1'b0;
            end
         end
         if (irq_ack_in && irq_out.valid) begin
            if (irq_out.high) begin
               high_active <= 1'b1;
            end else begin
               low_active <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         in_service_out <= 2'b00;
      end else begin
         in_service_out <= {high_active, low_active};
      end
   end

endmodule : iepr_ctrl

/* File: tb/iepr_ctrl_props.sv */
// checker of the interrupt enable and priority register block.
// assumes it sees only the top ports, all on clock_in.
`timescale 1ns/1ps
module iepr_ctrl_props (
   input wire logic                    clock_in,
   input wire logic                    sys_rst_in,
   input wire logic [7:0]              sfr_addr_in,
   input wire logic                    sfr_wr_in,
   input wire logic [7:0]              sfr_wdata_in,
   input wire logic                    sfr_rd_in,
   input wire logic                    global_irq_enable_in,
   input wire logic [6:0]              base_enable_in,
   input wire iepr_pkg::iepr_pending_t pending_in,
   input wire logic                    irq_ack_in,
   input wire logic                    irq_return_in,
   input wire logic [7:0]              sfr_rdata_out,
   input wire logic                    sfr_hit_out,
   input wire iepr_pkg::iepr_request_t irq_out,
   input wire logic [1:0]              in_service_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);
   logic mapped;
   assign mapped = sfr_addr_in inside {iepr_pkg::BASE_PRIO_ADDR,
      iepr_pkg::EXT_EN_ADDR, iepr_pkg::EXT_PRIO_ADDR};
   sequence s_taken;
      irq_ack_in && irq_out.valid;
   endsequence
   sequence s_read_once;
      sfr_rd_in ##1 !sfr_rd_in;
   endsequence
   a_fixed_top_bit: assert property (
      sfr_rd_in && sfr_addr_in == iepr_pkg::BASE_PRIO_ADDR
      |=> sfr_hit_out && sfr_rdata_out[7]) else $error("top bit low");
   a_unmapped_read: assert property (sfr_rd_in && !mapped
      |=> !sfr_hit_out && sfr_rdata_out == 8'h00) else $error("unmapped");
   a_read_release: assert property (s_read_once
      |=> !sfr_hit_out && sfr_rdata_out == 8'h00) else $error("held");
   a_global_block: assert property (
      !global_irq_enable_in |=> !irq_out.valid) else $error("global");
   a_ack_clears: assert property (s_taken |=> !irq_out.valid)
      else $error("request kept after ack");
   a_no_slot13: assert property (irq_out.valid |-> irq_out.slot != 4'hD)
      else $error("unused slot");
   // a return pulse frees a level one cycle before the output shows it
   a_high_blocks: assert property (
      in_service_out[1] && !$past(irq_return_in) |-> !irq_out.valid)
      else $error("request while high in service");
   a_low_waits: assert property (
      in_service_out[0] && !$past(irq_return_in) && irq_out.valid
      |-> irq_out.high) else $error("low request nested");
   a_ack_level: assert property (
      s_taken |-> ##2 in_service_out[$past(irq_out.high, 2)])
      else $error("level not in service");
endmodule : iepr_ctrl_props

bind iepr_ctrl iepr_ctrl_props props_u (.clock_in, .sys_rst_in,
   .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .sfr_rd_in,
   .global_irq_enable_in, .base_enable_in, .pending_in, .irq_ack_in,
   .irq_return_in, .sfr_rdata_out, .sfr_hit_out, .irq_out,
   .in_service_out);

/* File: tb/iepr_core_model.sv */
// core model: takes presented requests, ends routines after svc_in.
// assumes irq_in comes from the block on the same clock.
`timescale 1ns/1ps
module iepr_core_model (
   input  wire logic                    clock_in,
   input  wire logic                    sys_rst_in,
   input  wire iepr_pkg::iepr_request_t irq_in,
   input  wire logic                    take_in,
   input  wire logic [7:0]              svc_in,
   output logic                         irq_ack_out,
   output logic                         irq_return_out
);
   logic [7:0] cnt;
   logic [1:0] depth;
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         irq_ack_out <= 1'b0;
         irq_return_out <= 1'b0;
         cnt <= 8'h00;
         depth <= 2'h0;
      end else begin
         // ack only while a request is shown, never twice in a row
         irq_ack_out <= take_in && irq_in.valid && !irq_ack_out;
         irq_return_out <= depth != 2'h0 && cnt == svc_in;
         cnt <= (depth == 2'h0 || cnt == svc_in) ? 8'h00 : cnt + 8'h01;
         depth <= depth + 2'(irq_ack_out) - 2'(irq_return_out);
      end
   end
endmodule : iepr_core_model

/* File: tb/testbench.sv */
// testbench of the interrupt enable and priority register block.
// assumes the core model acks while take is high.
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] BP = iepr_pkg::BASE_PRIO_ADDR;
   localparam logic [7:0] EE = iepr_pkg::EXT_EN_ADDR;
   localparam logic [7:0] EP = iepr_pkg::EXT_PRIO_ADDR;
   logic clock_in, sys_rst_in, sfr_wr_in, sfr_rd_in, take;
   logic global_irq_enable_in, irq_ack_in, irq_return_in, sfr_hit_out;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
   logic [6:0] base_enable_in;
   logic [1:0] in_service_out;
   iepr_pkg::iepr_pending_t pending_in;
   iepr_pkg::iepr_request_t irq_out;
   int bad_count, compares;
   iepr_ctrl dut_u (.clock_in, .sys_rst_in, .sfr_addr_in, .sfr_wr_in,
      .sfr_wdata_in, .sfr_rd_in, .global_irq_enable_in, .base_enable_in,
      .pending_in, .irq_ack_in, .irq_return_in, .sfr_rdata_out,
      .sfr_hit_out, .irq_out, .in_service_out);
   iepr_core_model core_u (.clock_in, .sys_rst_in, .irq_in(irq_out),
      .take_in(take), .svc_in(8'h28), .irq_ack_out(irq_ack_in),
      .irq_return_out(irq_return_in));
   initial begin
      clock_in = 1'b0;
      forever #12.5 clock_in = ~clock_in;
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      tick(1);
      sfr_wr_in = 1'b0;
      tick(1);
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      tick(1);
      sfr_rd_in = 1'b0;
      cmp(sfr_rdata_out, e);
      cmp({7'h00, sfr_hit_out}, {7'h00, a inside {BP, EE, EP}});
      tick(1);
   endtask : rd_chk
   task automatic chk_irq(input logic [5:0] e);
      tick(1);
      cmp({2'h0, irq_out}, {2'h0, e});
   endtask : chk_irq
   function automatic iepr_pkg::iepr_pending_t pend(int s, bit alt);
      iepr_pkg::iepr_pending_t p;
      p = '0;
      case (s)
         0: p.ext_irq0 = 1'b1;
         1: p.timer0 = 1'b1;
         2: p.ext_irq1 = 1'b1;
         3: p.timer1 = 1'b1;
         4: p.uart_rx = 1'b1;
         5: p.timer2_low = 1'b1;
         6: p.spi = 4'h1;
         7: p.smbus = 1'b1;
         8: p.port_match = 1'b1;
         9: p.conv_window_flag = 1'b1;
         10: p.conv_done_flag = 1'b1;
         11: p.counter_array = 5'h01;
         12: {p.comparator_rise_flag,
            p.comparator_fall_flag} = alt ? 2'h1 : 2'h2;
         default: {p.timer3_high_overflow_flag,
            p.timer3_low_overflow_flag} = alt ? 2'h1 : 2'h2;
      endcase
      return p;
   endfunction : pend
   task automatic t_regs;
      rd_chk(BP, 8'h80);
      rd_chk(EE, 8'h00);
      rd_chk(EP, 8'h00);
      wr_reg(BP, 8'h15);
      rd_chk(BP, 8'h95);
      wr_reg(EE, 8'hA5);
      rd_chk(EE, 8'hA5);
      wr_reg(8'hA8, 8'hFF);
      rd_chk(8'hA8, 8'h00);
   endtask : t_regs
   task automatic t_base;
      wr_reg(EE, 8'h00);
      for (int i = 0; i < 7; i++) begin
         base_enable_in = 7'h01 << i;
         pending_in = pend(i, 1'b0);
         for (int h = 0; h < 2; h++) begin
            wr_reg(BP, 8'(h << i));
            chk_irq({1'b1, h[0], 4'(i)});
         end
         base_enable_in = 7'h00;
         chk_irq(6'h00);
      end
   endtask : t_base
   task automatic t_ext;
      for (int b = 0; b < 8; b++) begin
         if (b == 6) continue;
         wr_reg(EE, 8'(1 << b));
         for (int h = 0; h < 2; h++) begin
            pending_in = pend(b + 7, h[0]);
            wr_reg(EP, 8'(h << b));
            chk_irq({1'b1, h[0], 4'(b + 7)});
         end
         wr_reg(EE, 8'h00);
         chk_irq(6'h00);
      end
   endtask : t_ext
   task automatic t_nest;
      wr_reg(BP, 8'h02);
      base_enable_in = 7'h03;
      pending_in = pend(0, 1'b0) | pend(1, 1'b0);
      chk_irq(6'h31);
      global_irq_enable_in = 1'b0;
      chk_irq(6'h00);
      pending_in = pend(0, 1'b0);
      take = 1'b1;
      global_irq_enable_in = 1'b1;
      tick(6);
      cmp({6'h00, in_service_out}, 8'h01);
      pending_in = pend(0, 1'b0) | pend(1, 1'b0);
      tick(6);
      take = 1'b0;
      cmp({6'h00, in_service_out}, 8'h03);
      tick(100);
      cmp({6'h00, in_service_out}, 8'h00);
      cmp({2'h0, irq_out}, 8'h31);
   endtask : t_nest
   task automatic stop_test;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   initial begin
      {sys_rst_in, sfr_wr_in, sfr_rd_in, take} = 4'h8;
      {sfr_addr_in, sfr_wdata_in, base_enable_in} = '0;
      global_irq_enable_in = 1'b1;
      pending_in = '0;
      {bad_count, compares} = '0;
      tick(5);
      sys_rst_in = 1'b0;
      t_regs();
      t_base();
      t_ext();
      t_nest();
      stop_test();
   end
   initial begin
      // whole run is a few hundred cycles; this leaves ample margin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule : testbench
